// >>> logic/cpu_bank_pkg.sv
package cpu_bank_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned VEC_W = 20;
	localparam int unsigned BANK_FLAG_BIT = 4;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [19:0] RESET_VEC_BASE = 20'h00000;
	localparam logic [19:0] SPECIAL_PAGE_BASE = 20'hffe00;
	localparam logic [19:0] SPECIAL_PAGE_LAST = 20'hfffdb;
	localparam logic [19:0] FIXED_INT_BASE = 20'hfffdc;
	localparam logic [7:0] SPECIAL_PAGE_MIN = 8'h12;
	localparam logic [8:0] VAR_TABLE_BYTES = 9'h100;
	localparam logic [19:0] BIT_LIMIT_ABS = 20'h01fff;
	localparam logic [19:0] BIT_LIMIT_SB8 = 20'h0001f;
	localparam logic [19:0] BIT_LIMIT_SB11 = 20'h000ff;
	localparam logic [19:0] BIT_LIMIT_DSP8 = 20'h020fe;
	localparam logic [19:0] BIT_LIMIT_16 = 20'h0ffff;
	localparam logic [19:0] FB_LOW_SPAN = 20'h00010;
	localparam logic [19:0] FB_HIGH_SPAN = 20'h0000f;

	typedef enum logic [2:0] {
		REG_DATA0, REG_DATA1, REG_DATA2, REG_DATA3, REG_ADDR0, REG_ADDR1, REG_FRAME
	} bank_reg_e;

	typedef enum logic [2:0] {
		CTL_USP, CTL_ISP, CTL_SB, CTL_FLG, CTL_VTB_LO, CTL_VTB_HI
	} ctl_reg_e;

	// bit operand addressing forms
	typedef enum logic [3:0] {
		BIT_REG, BIT_ABS16, BIT_SB8, BIT_SB11, BIT_SB16, BIT_FB8, BIT_IND, BIT_DSP8, BIT_DSP16
	} bit_mode_e;

	typedef enum logic [1:0] {FMT_GENERIC, FMT_QUICK, FMT_SHORT, FMT_ZERO} fmt_e;

	typedef struct packed {
		logic [15:0] data0;
		logic [15:0] data1;
		logic [15:0] data2;
		logic [15:0] data3;
		logic [15:0] addr0;
		logic [15:0] addr1;
		logic [15:0] frame;
	} bank_s;

	typedef struct packed {
		bank_s bank0;
		bank_s bank1;
		logic [15:0] user_stack_pointer;
		logic [15:0] interrupt_stack_pointer;
		logic [15:0] sb;
		logic [15:0] flag_word;
		logic [19:0] vtb;
	} regs_s;

	typedef struct packed {
		logic valid;
		logic [1:0] kind;
		logic [2:0] idx;
		logic [15:0] data;
	} wr_s;

	typedef struct packed {
		logic [19:0] byte_addr;
		logic [2:0] bit_pos;
		logic in_range;
	} bit_ea_s;
endpackage

// >>> logic/bit_ea_calc.sv
`timescale 1ns/1ns
`default_nettype none
// combinational effective-address unit for bit operands
module bit_ea_calc (
	input wire cpu_bank_pkg::bit_mode_e mode_in,
	input wire logic [15:0] bit_field_in,
	input wire logic [15:0] disp_in,
	input wire logic [15:0] base_reg_in,
	input wire logic [15:0] areg_in,
	output cpu_bank_pkg::bit_ea_s ea_out
);
	import cpu_bank_pkg::*;
	logic [19:0] ref_addr;
	logic [19:0] bit_off;
	logic [19:0] lo_lim;
	logic [19:0] hi_lim;
	logic [19:0] target;

	// pick reference byte and bit offset per form
	always_comb begin
		ref_addr = 20'h00000;
		bit_off = {4'h0, bit_field_in};
		lo_lim = 20'h00000;
		hi_lim = BIT_LIMIT_16;
		unique case (mode_in)
			BIT_REG: begin
				bit_off = {16'h0000, bit_field_in[3:0]}; // RULE_06
				hi_lim = 20'h00001;
			end
			BIT_ABS16: begin
				ref_addr = {4'h0, disp_in}; // RULE_07
				hi_lim = BIT_LIMIT_ABS;
			end
			BIT_SB8, BIT_SB11, BIT_SB16, BIT_FB8: begin
				// RULE_08: displacement sign-extended only for the frame form
				if (mode_in == BIT_FB8) begin
					ref_addr = 20'({4'h0, base_reg_in} + {{12{disp_in[7]}}, disp_in[7:0]});
					lo_lim = 20'({4'h0, base_reg_in} - FB_LOW_SPAN);
					hi_lim = 20'({4'h0, base_reg_in} + FB_HIGH_SPAN);
				end else begin
					ref_addr = 20'({4'h0, base_reg_in} + {4'h0, disp_in});
					lo_lim = {4'h0, base_reg_in};
					hi_lim = 20'({4'h0, base_reg_in} + ((mode_in == BIT_SB8) ? BIT_LIMIT_SB8 :
						(mode_in == BIT_SB11) ? BIT_LIMIT_SB11 : BIT_LIMIT_ABS));
				end
			end
			BIT_IND: begin
				bit_off = {4'h0, areg_in}; // RULE_09
				hi_lim = BIT_LIMIT_ABS;
			end
			BIT_DSP8: begin
				ref_addr = {12'h000, disp_in[7:0]}; // RULE_10
				bit_off = {4'h0, areg_in};
				hi_lim = BIT_LIMIT_DSP8; // RULE_12
			end
			default: begin
				ref_addr = {4'h0, disp_in}; // RULE_10
				bit_off = {4'h0, areg_in};
				hi_lim = BIT_LIMIT_16; // RULE_12
			end
		endcase
		target = 20'(ref_addr + {3'h0, bit_off[19:3]}); // RULE_07
	end

	assign ea_out.byte_addr = target;
	assign ea_out.bit_pos = bit_off[2:0];
	// register form is always in range; memory forms are checked against range
	assign ea_out.in_range = (mode_in == BIT_REG) ? 1'b1 :
		((target >= lo_lim) && (target <= hi_lim) && (target <= BIT_LIMIT_16)); // RULE_12
endmodule
`default_nettype wire

// >>> logic/cpu_register_bank.sv
// Function
// RULE_01 - two banks of four data, two address, frame
// RULE_02 - flag word bit 4 picks the bank
// RULE_03 - all registers and table base reset to zero
// RULE_04 - signed values in two's complement
// RULE_05 - decimal add/subtract on packed BCD bytes/words
// RULE_06 - register bit numbers 0 to 15 only
// RULE_07 - memory bits form one continuous array
// RULE_08 - base register plus displacement is bit zero
// RULE_09 - indirect bit counts from address zero
// RULE_10 - relative bit counts from displacement address
// RULE_11 - software keeps bit operands within limits
// RULE_12 - bit access ranges bounded by form
// RULE_13 - strings are runs of bytes or words
// RULE_14 - generic form: two-byte opcode, 0-3 operand bytes
// RULE_15 - quick form: embedded small immediate, 0-2 bytes
// RULE_16 - short form: one-byte opcode, 0-2 each
// RULE_17 - zero form: implied zero immediate
// RULE_18 - special page entries at fixed table
// RULE_19 - fixed interrupt vectors from top area
// RULE_20 - operand sizes nibble, byte, word, long
// RULE_21 - relocatable table of 256 bytes at base
// RULE_22 - multi-byte values stored low byte first
`timescale 1ns/1ns
`default_nettype none
module cpu_register_bank (
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	input wire cpu_bank_pkg::wr_s wr_in,
	input wire cpu_bank_pkg::bank_reg_e rd_sel_in,
	input wire logic [1:0] rd_size_in,
	input wire cpu_bank_pkg::bit_mode_e bit_mode_in,
	input wire logic [15:0] bit_field_in,
	input wire logic [15:0] disp_in,
	input wire logic bit_base_fb_in,
	input wire logic [2:0] bit_reg_sel_in,
	input wire logic dec_valid_in,
	input wire logic dec_sub_in,
	input wire logic dec_word_in,
	input wire logic dec_carry_in,
	input wire logic [15:0] dec_a_in,
	input wire logic [15:0] dec_b_in,
	input wire logic [15:0] opcode_in,
	input wire logic [7:0] page_in,
	input wire logic [5:0] int_num_in,
	input wire logic [4:0] fixed_num_in,
	input wire logic str_word_in,
	input wire logic str_back_in,
	input wire logic [15:0] str_addr_in,
	output logic [15:0] rd_data_out,
	output logic rd_negative_out,
	output logic [31:0] long_data_out,
	output logic active_bank_out,
	output logic [15:0] flag_word_out,
	output logic [15:0] static_base_out,
	output logic [15:0] stack_pointer_out,
	output logic [19:0] vector_table_base_out,
	output cpu_bank_pkg::bit_ea_s bit_ea_out,
	output logic bit_value_out,
	output logic [15:0] dec_result_out,
	output logic dec_carry_out,
	output cpu_bank_pkg::fmt_e fmt_out,
	output logic [2:0] src_len_max_out,
	output logic [2:0] dst_len_max_out,
	output logic signed [4:0] quick_imm_out,
	output logic [19:0] page_entry_addr_out,
	output logic page_valid_out,
	output logic [19:0] int_vec_addr_out,
	output logic [19:0] fixed_vec_addr_out,
	output logic [15:0] str_next_addr_out
);
	import cpu_bank_pkg::*;

	typedef struct packed {
		regs_s regs;
		logic [15:0] dec_result;
		logic dec_carry;
	} state_s;

	state_s state_reg;
	state_s state_next;
	bank_s act_bank;
	logic [15:0] bank_word;
	logic [15:0] bit_areg;
	logic [15:0] dec_sum;
	logic dec_c;

	// active bank follows the flag word bank bit
	assign active_bank_out = state_reg.regs.flag_word[BANK_FLAG_BIT]; // RULE_02
	assign act_bank = active_bank_out ? state_reg.regs.bank1 : state_reg.regs.bank0; // RULE_01

	// read mux over the active bank
	always_comb begin
		unique case (rd_sel_in)
			REG_DATA0: bank_word = act_bank.data0;
			REG_DATA1: bank_word = act_bank.data1;
			REG_DATA2: bank_word = act_bank.data2;
			REG_DATA3: bank_word = act_bank.data3;
			REG_ADDR0: bank_word = act_bank.addr0;
			REG_ADDR1: bank_word = act_bank.addr1;
			default: bank_word = act_bank.frame;
		endcase
	end

	// operand width: nibble, byte, word; long pairs data2:data0
	always_comb begin
		unique case (rd_size_in)
			2'h0: rd_data_out = {12'h000, bank_word[3:0]}; // RULE_20
			2'h1: rd_data_out = {8'h00, bank_word[7:0]};
			default: rd_data_out = bank_word;
		endcase
	end
	assign long_data_out = {act_bank.data2, act_bank.data0}; // RULE_20
	// sign bit of the selected width under two's complement
	assign rd_negative_out = (rd_size_in == 2'h0) ? bank_word[3] :
		(rd_size_in == 2'h1) ? bank_word[7] : bank_word[15]; // RULE_04

	assign flag_word_out = state_reg.regs.flag_word;
	assign static_base_out = state_reg.regs.sb;
	assign vector_table_base_out = state_reg.regs.vtb;
	// flag word bit 7 selects user stack
	assign stack_pointer_out = state_reg.regs.flag_word[7] ? state_reg.regs.user_stack_pointer : state_reg.regs.interrupt_stack_pointer;

	// bit operand address; address register chosen from the active bank
	assign bit_areg = bit_reg_sel_in[0] ? act_bank.addr1 : act_bank.addr0;
	bit_ea_calc u_bit_ea (
		.mode_in(bit_mode_in),
		.bit_field_in(bit_field_in),
		.disp_in(disp_in),
		.base_reg_in(bit_base_fb_in ? act_bank.frame : state_reg.regs.sb), // RULE_08
		.areg_in(bit_areg),
		.ea_out(bit_ea_out)
	);
	// register bit read, positions 0..15 only
	assign bit_value_out = bank_word[bit_field_in[3:0]]; // RULE_06

	// packed BCD add/subtract, digit by digit with decimal adjust
	always_comb begin
		logic [4:0] d;
		logic c;
		d = 5'h00;
		c = dec_carry_in;
		dec_sum = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			if (!dec_sub_in) begin
				d = 5'({1'b0, dec_a_in[i*4 +: 4]} + {1'b0, dec_b_in[i*4 +: 4]} + {4'h0, c});
				c = (d > 5'h09);
				if (c) d = 5'(d + 5'h06);
			end else begin
				d = 5'({1'b0, dec_a_in[i*4 +: 4]} - {1'b0, dec_b_in[i*4 +: 4]} - {4'h0, c});
				c = d[4];
				if (c) d = 5'(d - 5'h06);
			end
			dec_sum[i*4 +: 4] = d[3:0]; // RULE_05
			if (i == 1 && !dec_word_in) break;
		end
		dec_c = c;
		if (!dec_word_in) dec_sum[15:8] = 8'h00;
	end
	assign dec_result_out = state_reg.dec_result;
	assign dec_carry_out = state_reg.dec_carry;

	// instruction format lengths from the first opcode byte
	always_comb begin
		quick_imm_out = 5'sh00;
		unique case (opcode_in[15:14])
			2'h0: begin
				fmt_out = FMT_GENERIC; // RULE_14
				src_len_max_out = 3'h3;
				dst_len_max_out = 3'h3;
			end
			2'h1: begin
				fmt_out = FMT_QUICK; // RULE_15
				src_len_max_out = 3'h0;
				dst_len_max_out = 3'h2;
				// one range is -8..+7, the other -7..+8
				quick_imm_out = opcode_in[13] ?
					5'(signed'({opcode_in[3], opcode_in[3:0]})) :
					5'(signed'({opcode_in[3], opcode_in[3:0]}) + 5'sh01);
			end
			2'h2: begin
				fmt_out = FMT_SHORT; // RULE_16
				src_len_max_out = 3'h2;
				dst_len_max_out = 3'h2;
			end
			default: begin
				fmt_out = FMT_ZERO; // RULE_17
				src_len_max_out = 3'h0;
				dst_len_max_out = 3'h2;
			end
		endcase
	end

	// vector addresses: special pages count back from the table top
	assign page_valid_out = (page_in >= SPECIAL_PAGE_MIN); // RULE_18
	assign page_entry_addr_out = 20'(SPECIAL_PAGE_LAST - 20'h00001 -
		{11'h000, (8'hff - page_in), 1'b0}); // RULE_18
	assign int_vec_addr_out = 20'(state_reg.regs.vtb + {12'h000, int_num_in, 2'b00}); // RULE_21
	assign fixed_vec_addr_out = 20'(FIXED_INT_BASE + {13'h0000, fixed_num_in, 2'b00}); // RULE_19

	// string pointer step by element size and direction
	assign str_next_addr_out = str_back_in ?
		16'(str_addr_in - (str_word_in ? 16'h0002 : 16'h0001)) :
		16'(str_addr_in + (str_word_in ? 16'h0002 : 16'h0001)); // RULE_13

	// register writes go to the active bank; results register on decimal ops
	always_comb begin
		bank_s wb;
		wb = active_bank_out ? state_reg.regs.bank1 : state_reg.regs.bank0;
		state_next = state_reg;
		if (wr_in.valid && wr_in.kind == 2'h0) begin
			unique case (bank_reg_e'(wr_in.idx))
				REG_DATA0: wb.data0 = wr_in.data;
				REG_DATA1: wb.data1 = wr_in.data;
				REG_DATA2: wb.data2 = wr_in.data;
				REG_DATA3: wb.data3 = wr_in.data;
				REG_ADDR0: wb.addr0 = wr_in.data;
				REG_ADDR1: wb.addr1 = wr_in.data;
				default: wb.frame = wr_in.data;
			endcase
			if (active_bank_out) state_next.regs.bank1 = wb; // RULE_01
			else state_next.regs.bank0 = wb;
		end else if (wr_in.valid && wr_in.kind == 2'h1) begin
			unique case (ctl_reg_e'(wr_in.idx))
				CTL_USP: state_next.regs.user_stack_pointer = wr_in.data;
				CTL_ISP: state_next.regs.interrupt_stack_pointer = wr_in.data;
				CTL_SB: state_next.regs.sb = wr_in.data;
				CTL_FLG: state_next.regs.flag_word = {1'b0, wr_in.data[14:12], 4'h0, wr_in.data[7:0]};
				// table base written low word first, then top nibble
				CTL_VTB_LO: state_next.regs.vtb[15:0] = wr_in.data; // RULE_22
				default: state_next.regs.vtb[19:16] = wr_in.data[3:0];
			endcase
		end
		if (dec_valid_in) begin
			state_next.dec_result = dec_sum;
			state_next.dec_carry = dec_c;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!reset_n_in) begin
			state_reg <= '0; // RULE_03
			state_reg.regs.flag_word <= RESET_WORD;
			state_reg.regs.vtb <= RESET_VEC_BASE;
		end else begin
			state_reg <= state_next;
		end
	end

	bank_flip_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		(wr_in.valid && wr_in.kind == 2'h1 && wr_in.idx == 3'(CTL_FLG))
		|=> (active_bank_out == $past(wr_in.data[4]))) // RULE_02
		else $error("bank select does not follow flag write");
	reset_zero_a: assert property (@(posedge clk_sys_in)
		!reset_n_in |=> (flag_word_out == 16'h0000 && vector_table_base_out == 20'h00000
		&& rd_data_out == 16'h0000)) // RULE_03
		else $error("registers not zero after reset");
	bank_isolate_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		(wr_in.valid && wr_in.kind == 2'h0 && !active_bank_out)
		|=> $stable(state_reg.regs.bank1)) // RULE_01
		else $error("write leaked into idle bank");
	dec_latch_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		(dec_valid_in && !dec_sub_in && !dec_carry_in && dec_a_in == 16'h0009
		&& dec_b_in == 16'h0001 && !dec_word_in) |=> (dec_result_out == 16'h0010)) // RULE_05
		else $error("bcd adjust wrong");
	page_addr_a: assert property (@(posedge clk_sys_in)
		(page_in == 8'hff) |-> (page_entry_addr_out == 20'hfffda)) // RULE_18
		else $error("last special page entry misplaced");
	fixed_vec_a: assert property (@(posedge clk_sys_in)
		(fixed_num_in == 5'h00) |-> (fixed_vec_addr_out == 20'hfffdc)) // RULE_19
		else $error("fixed vector base misplaced");
	// table base is unknown until the first reset edge, so the check waits for reset release
	int_vec_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		int_vec_addr_out - vector_table_base_out < 20'h00100) // RULE_21
		else $error("variable vector outside table");
	reg_bit_a: assert property (@(posedge clk_sys_in) (bit_mode_in == BIT_REG)
		|-> (bit_ea_out.bit_pos == bit_field_in[2:0])) // RULE_06
		else $error("register bit position wrong");
	abs_bit_a: assert property (@(posedge clk_sys_in) (bit_mode_in == BIT_ABS16)
		|-> (bit_ea_out.byte_addr == 20'({4'h0, disp_in} + {7'h00, bit_field_in[15:3]}))) // RULE_07
		else $error("absolute bit byte address wrong");
	str_step_a: assert property (@(posedge clk_sys_in) (str_word_in && !str_back_in)
		|-> (str_next_addr_out == 16'(str_addr_in + 16'h0002))) // RULE_13
		else $error("string word step wrong");
	zero_fmt_a: assert property (@(posedge clk_sys_in) (fmt_out == FMT_ZERO)
		|-> (quick_imm_out == 5'sh00 && src_len_max_out == 3'h0)) // RULE_17
		else $error("zero form carries operand");
endmodule
`default_nettype wire

// >>> test/cpu_register_bank_bit_addressing_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cpu_register_bank_bit_addressing_tb;
	import cpu_bank_pkg::*;
	logic clk_sys_in, reset_n_in, bit_base_fb_in, dec_valid_in, dec_sub_in, dec_word_in;
	logic dec_carry_in, str_word_in, str_back_in;
	wr_s wr_in;
	bank_reg_e rd_sel_in;
	bit_mode_e bit_mode_in;
	logic [1:0] rd_size_in;
	logic [2:0] bit_reg_sel_in;
	logic [15:0] bit_field_in, disp_in, dec_a_in, dec_b_in, opcode_in, str_addr_in;
	logic [7:0] page_in;
	logic [5:0] int_num_in;
	logic [4:0] fixed_num_in;
	logic [15:0] rd_data_out, flag_word_out, static_base_out, stack_pointer_out;
	logic [15:0] dec_result_out, str_next_addr_out;
	logic [31:0] long_data_out;
	logic rd_negative_out, active_bank_out, bit_value_out, dec_carry_out, page_valid_out;
	logic [19:0] vector_table_base_out, page_entry_addr_out, int_vec_addr_out, fixed_vec_addr_out;
	bit_ea_s bit_ea_out;
	fmt_e fmt_out;
	logic [2:0] src_len_max_out, dst_len_max_out;
	logic signed [4:0] quick_imm_out;
	int n_fail = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h7ac31b57;
	logic [15:0] va, vb, vc;
	logic [19:0] e;

	cpu_register_bank i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wr_in(wr_in),
		.rd_sel_in(rd_sel_in), .rd_size_in(rd_size_in), .bit_mode_in(bit_mode_in),
		.bit_field_in(bit_field_in), .disp_in(disp_in), .bit_base_fb_in(bit_base_fb_in),
		.bit_reg_sel_in(bit_reg_sel_in), .dec_valid_in(dec_valid_in), .dec_sub_in(dec_sub_in),
		.dec_word_in(dec_word_in), .dec_carry_in(dec_carry_in), .dec_a_in(dec_a_in),
		.dec_b_in(dec_b_in), .opcode_in(opcode_in), .page_in(page_in), .int_num_in(int_num_in),
		.fixed_num_in(fixed_num_in), .str_word_in(str_word_in), .str_back_in(str_back_in),
		.str_addr_in(str_addr_in), .rd_data_out(rd_data_out), .rd_negative_out(rd_negative_out),
		.long_data_out(long_data_out), .active_bank_out(active_bank_out),
		.flag_word_out(flag_word_out), .static_base_out(static_base_out),
		.stack_pointer_out(stack_pointer_out), .vector_table_base_out(vector_table_base_out),
		.bit_ea_out(bit_ea_out), .bit_value_out(bit_value_out), .dec_result_out(dec_result_out),
		.dec_carry_out(dec_carry_out), .fmt_out(fmt_out), .src_len_max_out(src_len_max_out),
		.dst_len_max_out(dst_len_max_out), .quick_imm_out(quick_imm_out),
		.page_entry_addr_out(page_entry_addr_out), .page_valid_out(page_valid_out),
		.int_vec_addr_out(int_vec_addr_out), .fixed_vec_addr_out(fixed_vec_addr_out),
		.str_next_addr_out(str_next_addr_out));

	// free-running system clock, 50 ns period
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end

	// xorshift keeps every run identical for the same seed
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// random packed decimal word, every digit 0..9
	function automatic logic [15:0] mk_bcd();
		logic [15:0] r;
		for (int n = 0; n < 4; n++) r[n*4+:4] = 4'(rnd() % 10);
		return r;
	endfunction

	// digit-serial decimal model; upper byte stays zero in byte mode
	function automatic logic [16:0] bcd(input logic [15:0] a, input logic [15:0] b,
		input logic c, input logic s, input logic w);
		logic [15:0] r;
		int d;
		r = 16'h0000;
		for (int n = 0; n < (w ? 4 : 2); n++) begin
			d = s ? int'(a[n*4+:4]) - int'(b[n*4+:4]) - int'(c) : int'(a[n*4+:4]) + int'(b[n*4+:4]) + int'(c);
			c = s ? (d < 0) : (d > 9);
			if (s && d < 0) d += 10;
			if (!s && d > 9) d -= 10;
			r[n*4+:4] = 4'(d);
		end
		return {c, r};
	endfunction

	// one write cycle; the value is visible once this returns
	task automatic wr(input logic [1:0] k, input logic [2:0] i, input logic [15:0] d);
		@(posedge clk_sys_in);
		wr_in <= '{valid: 1'b1, kind: k, idx: i, data: d};
		@(posedge clk_sys_in);
		wr_in.valid <= 1'b0;
		#1;
	endtask

	// combinational read of the active bank
	task automatic rd(input bank_reg_e s, input logic [1:0] z, input logic [15:0] bf);
		@(posedge clk_sys_in);
		rd_sel_in <= s;
		rd_size_in <= z;
		bit_field_in <= bf;
		#1;
	endtask

	task automatic dec(input logic [15:0] a, input logic [15:0] b, input logic [2:0] csw);
		logic [16:0] x;
		x = bcd(a, b, csw[2], csw[1], csw[0]);
		@(posedge clk_sys_in);
		{dec_valid_in, dec_a_in, dec_b_in, dec_carry_in, dec_sub_in, dec_word_in} <= {1'b1, a, b, csw};
		@(posedge clk_sys_in);
		dec_valid_in <= 1'b0;
		#1;
		`CHK({dec_carry_out, dec_result_out}, x)
	endtask

	task automatic end_sim();
		if (n_fail == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// watchdog: the sequence needs about 600 cycles
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_fail++;
		end_sim();
	end

	initial begin
		{reset_n_in, bit_base_fb_in, dec_valid_in, dec_sub_in, dec_word_in} = 5'h00;
		{dec_carry_in, str_word_in, str_back_in, rd_size_in, bit_reg_sel_in} = 8'h00;
		{bit_field_in, disp_in, dec_a_in, dec_b_in, opcode_in, str_addr_in} = 96'h0;
		{page_in, int_num_in, fixed_num_in} = 19'h0;
		wr_in = '0;
		rd_sel_in = REG_DATA0;
		bit_mode_in = BIT_IND;
		repeat (5) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		#1;
		`CHK({flag_word_out, static_base_out, stack_pointer_out, active_bank_out}, 49'h0)
		`CHK(vector_table_base_out, 20'h00000)
		for (int i = 0; i < 7; i++) begin
			rd(bank_reg_e'(3'(i)), 2'h2, 16'h0000);
			`CHK(rd_data_out, 16'h0000)
		end
		// banks hold separate copies, selected by flag bit 4
		va = rnd();
		vb = rnd();
		wr(2'h0, 3'h0, va);
		wr(2'h1, 3'h3, 16'h0010);
		`CHK(active_bank_out, 1'b1)
		rd(REG_DATA0, 2'h2, 16'h0000);
		`CHK(rd_data_out, 16'h0000)
		wr(2'h0, 3'h0, vb);
		rd(REG_DATA0, 2'h2, 16'h0000);
		`CHK(rd_data_out, vb)
		wr(2'h1, 3'h3, 16'h0000);
		rd(REG_DATA0, 2'h2, 16'h0000);
		`CHK({active_bank_out, rd_data_out}, {1'b0, va})
		// stack select follows flag bit 7; reserved flag bits never stick
		wr(2'h1, 3'h0, va);
		wr(2'h1, 3'h1, vb);
		wr(2'h1, 3'h3, 16'hffff);
		`CHK({flag_word_out, stack_pointer_out}, {16'h70ff, va})
		wr(2'h1, 3'h3, 16'h0000);
		`CHK(stack_pointer_out, vb)
		// operand widths, sign bit and register bit select
		for (int k = 0; k < 6; k++) begin
			va = rnd();
			vb = rnd();
			wr(2'h0, 3'h0, va);
			wr(2'h0, 3'h2, vb);
			`CHK(long_data_out, {vb, va})
			for (int z = 0; z < 4; z++) begin
				vc = rnd();
				rd(REG_DATA0, 2'(z), {12'h000, vc[3:0]});
				e = (z == 0) ? 20'h0000f : (z == 1) ? 20'h000ff : 20'h0ffff;
				`CHK(rd_data_out, va & e[15:0])
				`CHK(rd_negative_out, (z == 0) ? va[3] : (z == 1) ? va[7] : va[15])
				`CHK(bit_value_out, va[vc[3:0]])
			end
		end
		// bit addresses: continuous bit array from each base
		for (int k = 0; k < 16; k++) begin
			va = rnd();
			vb = 16'(rnd() & 32'h3fff);
			wr(2'h0, 3'(4 + k % 2), va);
			wr(2'h1, 3'h2, vb);
			vc = 16'(rnd() & 32'h0fff);
			@(posedge clk_sys_in);
			bit_reg_sel_in <= 3'(k % 2);
			bit_field_in <= 16'(rnd());
			disp_in <= vc;
			bit_mode_in <= (k % 4 == 0) ? BIT_IND : (k % 4 == 1) ? BIT_DSP16 : (k % 4 == 2) ? BIT_SB16 : BIT_ABS16;
			#1;
			case (k % 4)
				0: `CHK({bit_ea_out.byte_addr, bit_ea_out.bit_pos}, {7'h0, va})
				1: `CHK({bit_ea_out.byte_addr, bit_ea_out.bit_pos}, {20'(vc) + 20'(va[15:3]), va[2:0]})
				2: `CHK({bit_ea_out.byte_addr, bit_ea_out.bit_pos}, {20'(vb) + 20'(vc) + 20'(bit_field_in[15:3]), bit_field_in[2:0]})
				default: `CHK({bit_ea_out.byte_addr, bit_ea_out.bit_pos}, {20'(vc) + 20'(bit_field_in[15:3]), bit_field_in[2:0]})
			endcase
			// absolute and 16-bit static-base forms reach at most 01fff past their base
			`CHK(bit_ea_out.in_range, (k % 4 >= 2) ? (20'(vc) + 20'(bit_field_in[15:3]) <= 20'h01fff) : 1'b1)
			`CHK(static_base_out, vb)
		end
		// decimal corners, then random operands in every mode
		dec(16'h0009, 16'h0001, 3'h1);
		dec(16'h9999, 16'h0001, 3'h1);
		dec(16'h0000, 16'h0001, 3'h3);
		dec(16'h0099, 16'h0000, 3'h4);
		for (int k = 0; k < 16; k++) dec(mk_bcd(), mk_bcd(), 3'(k));
		// format decode with random opcodes
		for (int k = 0; k < 48; k++) begin
			vc = rnd();
			@(posedge clk_sys_in);
			opcode_in <= vc;
			#1;
			`CHK(fmt_out, fmt_e'(vc[15:14]))
			`CHK({src_len_max_out, dst_len_max_out}, (vc[15:14] == 0) ? 6'o33 : (vc[15:14] == 2) ? 6'o22 : 6'o02)
			if (vc[15:14] == 1) `CHK(quick_imm_out, $signed({vc[3], vc[3:0]}) + 5'sd1 - 5'(vc[13]))
		end
		// special page table, fixed vectors, relocatable table, strings
		for (int p = 0; p < 256; p++) begin
			@(posedge clk_sys_in);
			page_in <= 8'(p);
			fixed_num_in <= 5'(p % 9);
			str_addr_in <= 16'(rnd());
			{str_word_in, str_back_in} <= 2'(p);
			#1;
			`CHK(page_valid_out, p >= 18)
			if (p >= 18) `CHK(page_entry_addr_out, 20'hffe00 + 20'(2 * (p - 18)))
			`CHK(fixed_vec_addr_out, 20'hfffdc + 20'(4 * (p % 9)))
			`CHK(str_next_addr_out, str_back_in ? str_addr_in - (str_word_in ? 16'h2 : 16'h1) : str_addr_in + (str_word_in ? 16'h2 : 16'h1))
		end
		va = rnd();
		wr(2'h1, 3'h4, va & 16'hff00);
		wr(2'h1, 3'h5, 16'h000a);
		`CHK(vector_table_base_out, {4'ha, va[15:8], 8'h00})
		for (int n = 0; n < 64; n++) begin
			@(posedge clk_sys_in);
			int_num_in <= 6'(n);
			#1;
			`CHK(int_vec_addr_out, {4'ha, va[15:8], 8'(4 * n)})
		end
		end_sim();
	end
endmodule
`default_nettype wire
